// *** src/pcl_defines.vh ***
// Register map, field positions and encodings for the port link control block.
`ifndef PCL_DEFINES_VH
`define PCL_DEFINES_VH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define PCL_A_CTL      8'h00
`define PCL_A_STS      8'h04
`define PCL_A_LCAP0    8'h08
`define PCL_A_LSTS0    8'h14
`define PCL_A_SCAP0    8'h20
`define PCL_A_IST_INT  8'h2c
`define PCL_A_IST_EXT  8'h30
`define PCL_A_IACT_INT 8'h34
`define PCL_A_IACT_EXT 8'h38
`define PCL_A_STEP     8'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PCL_CTL_UNLOCK 0
`define PCL_CTL_REV    1
`define PCL_LW_LSB     4
`define PCL_LW_MSB     9
`define PCL_LSTS_DLA   13
`define PCL_LSTS_ROLE  14

// ----------------------------------------
// Link widths and reset values
// ----------------------------------------
`define PCL_W_NONE 6'h00
`define PCL_W_X1   6'h01
`define PCL_W_X2   6'h02
`define PCL_W_X4   6'h04
`define PCL_SCAP_RST 32'h00000000

// ----------------------------------------
// Training state codes and ordered-set identifiers
// ----------------------------------------
`define PCL_LT_L0   4'h3
`define PCL_LT_L0S  4'h4
`define PCL_LT_L1   4'h5
`define PCL_LT_REC  4'h6
`define PCL_TS1_ID  8'h4a
`define PCL_TS2_ID  8'h45
`define PCL_SYM_FIRST 4'h6
`define PCL_SYM_LAST  4'hf

// ----------------------------------------
// Interrupt actions and advertised credits
// ----------------------------------------
`define PCL_ACT_INTX 2'h1
`define PCL_ACT_MSI  2'h2
`define PCL_FC_PH    8'h1e
`define PCL_FC_PD    12'h0cc
`define PCL_FC_NPH   8'h1e
`define PCL_FC_NPD   12'h01e
`define PCL_FC_CPLH  8'h1e
`define PCL_FC_CPLD  12'h0cc

`endif

// *** src/pcl_lane_pol.v ***
// Per-lane receive polarity detection and correction.
`timescale 1ns/100ps
`default_nettype none
`include "pcl_defines.vh"

module pcl_lane_pol
(
	// Clock and reset
	input  wire       clk_sys,
	input  wire       rst_n,
	// Received symbols
	input  wire       training,
	input  wire       sym_valid,
	input  wire [3:0] sym_idx,
	input  wire [7:0] sym_in,
	// Corrected symbols
	output reg        inverted,
	output reg  [7:0] sym_out
);

	wire in_range;
	wire seen_norm;
	wire seen_inv;
	wire next_inv;

	// ----------------------------------------
	// Detection
	// ----------------------------------------
	// Only the identifier symbols of TS1 and TS2 are judged, so payload bytes never flip a lane.
	assign in_range  = training && sym_valid &&
	                   (sym_idx >= `PCL_SYM_FIRST) && (sym_idx <= `PCL_SYM_LAST);
	assign seen_norm = in_range && ((sym_in == `PCL_TS1_ID) || (sym_in == `PCL_TS2_ID));
	assign seen_inv  = in_range && ((sym_in == ~`PCL_TS1_ID) || (sym_in == ~`PCL_TS2_ID));
	assign next_inv  = seen_inv ? 1'b1 : (seen_norm ? 1'b0 : inverted);

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			inverted <= 1'b0;
			sym_out  <= 8'h00;
		end
		else
		begin
			inverted <= next_inv;
			sym_out  <= next_inv ? ~sym_in : sym_in;
		end
	end

endmodule
`default_nettype wire

// *** src/pcl_lane_map.v ***
// Static lane reversal mapping and unused-lane selection for one four-lane port.
`timescale 1ns/100ps
`default_nettype none
`include "pcl_defines.vh"

module pcl_lane_map
(
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// Configuration latched at training
	input  wire        rev,
	input  wire [5:0]  max_w,
	input  wire [5:0]  neg_w,
	// Lane data
	input  wire [31:0] phys_in,
	output reg  [31:0] log_out,
	output reg  [3:0]  phys_unused
);

	// The mapping is its own inverse, so it serves for both directions.
	function [1:0] peer;
		input [1:0] idx;
		input       r;
		input [5:0] mw;
		begin
			if (r && (mw == `PCL_W_X4))
				peer = ~idx;
			else if (r && (mw == `PCL_W_X2) && !idx[1])
				peer = {1'b0, ~idx[0]};
			else
				peer = idx;
		end
	endfunction

	// ----------------------------------------
	// Per-lane mapping
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : lane
			localparam [1:0] IDX = g;
			wire [1:0] src;
			assign src = peer(IDX, rev, max_w);
			always @(posedge clk_sys)
			begin
				if (!rst_n)
				begin
					log_out[8*g+7:8*g] <= 8'h00;
					phys_unused[g]     <= 1'b0;
				end
				else
				begin
					log_out[8*g+7:8*g] <= phys_in[8*src +: 8];
					phys_unused[g]     <= (neg_w != `PCL_W_NONE) &&
					                      ({4'h0, src} >= neg_w);
				end
			end
		end
	endgenerate

endmodule
`default_nettype wire

// *** src/pcl_top.v ***
// Link control for three switch ports: polarity, width, reversal, link events and registers.
//
// Function
// - Receiver checks TS1/TS2 identifier symbols for inverted polarity and corrects its data.
// - Polarity is detected and held per lane, independent of other lanes.
// - Each four-lane port negotiates to x4, x2 or x1 at training.
// - Negotiated width is shown in the port's link status register width field.
// - Maximum width field is writable only while the unlock bit is set.
// - A new maximum width applies only at the next training.
// - Lanes unused by a narrower link are put into the low-power state.
// - No automatic reversal; only static reversal chosen per port.
// - Reversal straps are sampled in reset and seed the reversal control bits.
// - Sampled strap values are kept read-only in the switch status register.
// - Training reads the port's reversal bit and reverses its lanes if set.
// - Retraining resets no settings back to their defaults.
// - When a link goes down, its queued received packets are discarded.
// - Packets targeting a port whose link is down are unsupported requests.
// - Configuration access to a down port's bridge is still accepted.
// - A write causing retraining or bus reset always keeps its completion.
// - On link up, credits matching the input buffer size are advertised.
// - Downstream ports send slot power limit on slot write while up, or link up.
// - Port A trains upstream only, B downstream only, C crosslinks with either.
// - Active-low link-up output follows L0, L0s, L1 or Recovery.
// - Link up and down transitions set flags in both endpoint status registers.
// - Each set flag triggers none, INTx or MSI per domain action field.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "pcl_defines.vh"

module pcl_top
(
	// Clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// Reversal straps
	input  wire        port_a_reverse_strap,
	input  wire        port_b_reverse_strap,
	input  wire        port_c_reverse_strap,
	// Register port
	input  wire [7:0]  reg_addr,
	input  wire [31:0] reg_wdata,
	input  wire        reg_wr,
	input  wire        reg_rd,
	output reg  [31:0] reg_rdata,
	// Receive lanes, twelve lanes, four per port
	input  wire [95:0] rx_sym,
	input  wire [47:0] rx_sym_idx,
	input  wire [11:0] rx_sym_valid,
	output wire [95:0] rx_log_data,
	output wire [11:0] lane_inverted,
	output wire [11:0] lane_l1,
	// Training, per port
	input  wire [11:0] ltssm_state,
	input  wire [2:0]  train_start,
	input  wire [2:0]  train_done,
	input  wire [17:0] partner_width,
	input  wire [2:0]  partner_is_down,
	output wire [2:0]  role_mismatch,
	// Link events and packet handling, per port
	output wire [2:0]  port_link_up_n,
	output wire [2:0]  discard_req,
	output wire [2:0]  ur_route,
	input  wire [2:0]  cfg_retrain_wr,
	input  wire [2:0]  cpl_sent,
	output wire [2:0]  keep_cpl,
	output wire [2:0]  fc_init,
	output reg  [59:0] fc_credits,
	output wire [2:0]  spl_send,
	// Endpoint interrupts, internal then external
	output reg  [1:0]  intx_req,
	output reg  [1:0]  msi_req
);

	// ----------------------------------------
	// Shared control and status registers
	// ----------------------------------------
	reg        write_unlock_bit;
	reg        port_a_reverse_bit;
	reg        port_b_reverse_bit;
	reg        port_c_reverse_bit;
	reg  [2:0] strap_seen;
	reg  [5:0] act_int;
	reg  [5:0] act_ext;

	wire [2:0]  rev_bits;
	wire [95:0] port_rd;
	wire [5:0]  sts_int;
	wire [5:0]  sts_ext;
	wire [5:0]  intx_int;
	wire [5:0]  intx_ext;
	wire [2:0]  msi_int;
	wire [2:0]  msi_ext;
	wire [95:0] lane_fixed;
	wire        wr_ctl;
	wire        wr_ist_int;
	wire        wr_ist_ext;
	reg  [31:0] next_rdata;

	assign rev_bits   = {port_c_reverse_bit, port_b_reverse_bit, port_a_reverse_bit};
	assign wr_ctl     = reg_wr && (reg_addr == `PCL_A_CTL);
	assign wr_ist_int = reg_wr && (reg_addr == `PCL_A_IST_INT);
	assign wr_ist_ext = reg_wr && (reg_addr == `PCL_A_IST_EXT);

	// Straps are caught by the clocked reset branch, so the control bits start from the pins
	// and only a fundamental reset reloads them; retraining leaves them alone.
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			strap_seen <= {port_c_reverse_strap, port_b_reverse_strap,
			               port_a_reverse_strap};
			port_a_reverse_bit <= port_a_reverse_strap;
			port_b_reverse_bit <= port_b_reverse_strap;
			port_c_reverse_bit <= port_c_reverse_strap;
			write_unlock_bit   <= 1'b0;
			act_int            <= 6'h00;
			act_ext            <= 6'h00;
			fc_credits         <= {`PCL_FC_CPLD, `PCL_FC_CPLH, `PCL_FC_NPD,
			                       `PCL_FC_NPH, `PCL_FC_PD, `PCL_FC_PH};
		end
		else
		begin
			if (wr_ctl)
			begin
				write_unlock_bit   <= reg_wdata[`PCL_CTL_UNLOCK];
				port_a_reverse_bit <= reg_wdata[`PCL_CTL_REV];
				port_b_reverse_bit <= reg_wdata[`PCL_CTL_REV+1];
				port_c_reverse_bit <= reg_wdata[`PCL_CTL_REV+2];
			end
			if (reg_wr && (reg_addr == `PCL_A_IACT_INT))
				act_int <= reg_wdata[5:0];
			if (reg_wr && (reg_addr == `PCL_A_IACT_EXT))
				act_ext <= reg_wdata[5:0];
		end
	end

	// ----------------------------------------
	// Polarity correction, one instance per lane
	// ----------------------------------------
	genvar l;
	generate
		for (l = 0; l < 12; l = l + 1)
		begin : lane
			wire trn;
			assign trn = (ltssm_state[4*(l/4)+3:4*(l/4)] != `PCL_LT_L0);
			pcl_lane_pol u_pol
			(
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.training  (trn),
				.sym_valid (rx_sym_valid[l]),
				.sym_idx   (rx_sym_idx[4*l+3:4*l]),
				.sym_in    (rx_sym[8*l+7:8*l]),
				.inverted  (lane_inverted[l]),
				.sym_out   (lane_fixed[8*l+7:8*l])
			);
		end
	endgenerate

	// ----------------------------------------
	// Per-port link logic
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1)
		begin : port
			localparam [7:0] A_LCAP = `PCL_A_LCAP0 + `PCL_A_STEP * g;
			localparam [7:0] A_LSTS = `PCL_A_LSTS0 + `PCL_A_STEP * g;
			localparam [7:0] A_SCAP = `PCL_A_SCAP0 + `PCL_A_STEP * g;
			localparam       IS_DS  = (g != 0);

			reg  [5:0]  max_width_field;
			reg  [5:0]  max_lat;
			reg         rev_lat;
			reg  [5:0]  negotiated_width;
			reg         role_err;
			reg  [31:0] slot_cap;
			reg         dl_prev;
			reg         up_n;
			reg         disc;
			reg         fcp;
			reg         spl;
			reg         keep;
			reg         up_i;
			reg         dn_i;
			reg         up_e;
			reg         dn_e;
			wire [3:0]  lt;
			wire        dl_up;
			wire        came_up;
			wire        went_down;
			wire [5:0]  pw;
			wire [5:0]  next_w;
			wire        role_ok;
			wire [31:0] link_status_reg;

			assign lt        = ltssm_state[4*g+3:4*g];
			assign dl_up     = (lt == `PCL_LT_L0) || (lt == `PCL_LT_L0S) ||
			                   (lt == `PCL_LT_L1) || (lt == `PCL_LT_REC);
			assign came_up   = dl_up && !dl_prev;
			assign went_down = !dl_up && dl_prev;
			assign pw        = partner_width[6*g+5:6*g];
			// Port A needs a downstream partner, B an upstream one, C takes either.
			assign role_ok   = (g == 2) || (partner_is_down[g] == (g == 0));
			assign next_w    = (pw < max_lat) ? pw : max_lat;

			always @(posedge clk_sys)
			begin
				if (!rst_n)
				begin
					max_width_field  <= `PCL_W_X4;
					max_lat          <= `PCL_W_X4;
					rev_lat          <= 1'b0;
					negotiated_width <= `PCL_W_NONE;
					role_err         <= 1'b0;
					slot_cap         <= `PCL_SCAP_RST;
					dl_prev          <= 1'b0;
					up_n             <= 1'b1;
					disc             <= 1'b0;
					fcp              <= 1'b0;
					spl              <= 1'b0;
					keep             <= 1'b0;
					up_i             <= 1'b0;
					dn_i             <= 1'b0;
					up_e             <= 1'b0;
					dn_e             <= 1'b0;
				end
				else
				begin
					// Accepted whatever the link state, so a down port stays configurable.
					if (reg_wr && (reg_addr == A_LCAP) && write_unlock_bit &&
					    ((reg_wdata[`PCL_LW_MSB:`PCL_LW_LSB] == `PCL_W_X1) ||
					     (reg_wdata[`PCL_LW_MSB:`PCL_LW_LSB] == `PCL_W_X2) ||
					     (reg_wdata[`PCL_LW_MSB:`PCL_LW_LSB] == `PCL_W_X4)))
						max_width_field <= reg_wdata[`PCL_LW_MSB:`PCL_LW_LSB];
					if (reg_wr && (reg_addr == A_SCAP))
						slot_cap <= reg_wdata;
					// The live link keeps its bound; the field only matters at the next start.
					if (train_start[g])
					begin
						max_lat <= max_width_field;
						rev_lat <= rev_bits[g];
					end
					if (train_done[g])
					begin
						negotiated_width <= role_ok ? next_w : `PCL_W_NONE;
						role_err         <= !role_ok;
					end
					dl_prev <= dl_up;
					up_n    <= !dl_up;
					disc    <= went_down;
					fcp     <= came_up;
					spl     <= IS_DS && (came_up ||
					           (dl_up && reg_wr && (reg_addr == A_SCAP)));
					// A completion marked here is withheld from the discard until sent.
					if (cfg_retrain_wr[g])
						keep <= 1'b1;
					else if (cpl_sent[g])
						keep <= 1'b0;
					// Set wins over a write-one-to-clear in the same cycle.
					up_i <= came_up || (up_i && !(wr_ist_int && reg_wdata[2*g]));
					dn_i <= went_down || (dn_i && !(wr_ist_int && reg_wdata[2*g+1]));
					up_e <= came_up || (up_e && !(wr_ist_ext && reg_wdata[2*g]));
					dn_e <= went_down || (dn_e && !(wr_ist_ext && reg_wdata[2*g+1]));
				end
			end

			assign link_status_reg = {16'h0000, 1'b0, role_err, dl_up, 3'h0,
			                          negotiated_width, 4'h0};
			assign port_rd[32*g+31:32*g] =
				(reg_addr == A_LCAP) ? {22'h0, max_width_field, 4'h0} :
				(reg_addr == A_LSTS) ? link_status_reg :
				(reg_addr == A_SCAP) ? slot_cap : 32'h00000000;

			assign sts_int[2*g+1:2*g]  = {dn_i, up_i};
			assign sts_ext[2*g+1:2*g]  = {dn_e, up_e};
			assign intx_int[2*g+1:2*g] = (act_int[2*g+1:2*g] == `PCL_ACT_INTX) ?
			                             {dn_i, up_i} : 2'b00;
			assign intx_ext[2*g+1:2*g] = (act_ext[2*g+1:2*g] == `PCL_ACT_INTX) ?
			                             {dn_e, up_e} : 2'b00;
			assign msi_int[g] = (came_up || went_down) &&
			                    (act_int[2*g+1:2*g] == `PCL_ACT_MSI);
			assign msi_ext[g] = (came_up || went_down) &&
			                    (act_ext[2*g+1:2*g] == `PCL_ACT_MSI);

			assign port_link_up_n[g] = up_n;
			assign discard_req[g]    = disc && !keep;
			assign ur_route[g]       = up_n;
			assign keep_cpl[g]       = keep;
			assign fc_init[g]        = fcp;
			assign spl_send[g]       = spl;
			assign role_mismatch[g]  = role_err;

			pcl_lane_map u_map
			(
				.clk_sys     (clk_sys),
				.rst_n       (rst_n),
				.rev         (rev_lat),
				.max_w       (max_lat),
				.neg_w       (negotiated_width),
				.phys_in     (lane_fixed[32*g+31:32*g]),
				.log_out     (rx_log_data[32*g+31:32*g]),
				.phys_unused (lane_l1[4*g+3:4*g])
			);
		end
	endgenerate

	// ----------------------------------------
	// Read data and interrupt outputs
	// ----------------------------------------
	always @*
	begin
		next_rdata = port_rd[31:0] | port_rd[63:32] | port_rd[95:64];
		case (reg_addr)
			`PCL_A_CTL:      next_rdata = {28'h0, rev_bits, write_unlock_bit};
			`PCL_A_STS:      next_rdata = {29'h0, strap_seen};
			`PCL_A_IST_INT:  next_rdata = {26'h0, sts_int};
			`PCL_A_IST_EXT:  next_rdata = {26'h0, sts_ext};
			`PCL_A_IACT_INT: next_rdata = {26'h0, act_int};
			`PCL_A_IACT_EXT: next_rdata = {26'h0, act_ext};
			default:         next_rdata = next_rdata;
		endcase
	end

	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 32'h00000000;
			intx_req  <= 2'b00;
			msi_req   <= 2'b00;
		end
		else
		begin
			reg_rdata <= reg_rd ? next_rdata : 32'h00000000;
			intx_req  <= {|intx_ext, |intx_int};
			msi_req   <= {|msi_ext, |msi_int};
		end
	end

endmodule
`default_nettype wire

// *** tb/pcl_assertions.sv ***
// Concurrent checks on the outputs of the port link control block.
`timescale 1ns/100ps
`default_nettype none
`include "pcl_defines.vh"

module pcl_assertions
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst_n,
	// Lanes and training
	input wire logic [95:0] rx_sym,
	input wire logic [47:0] rx_sym_idx,
	input wire logic [11:0] rx_sym_valid,
	input wire logic [11:0] lane_inverted,
	input wire logic [11:0] ltssm_state,
	input wire logic [2:0]  train_done,
	input wire logic [2:0]  partner_is_down,
	input wire logic [2:0]  role_mismatch,
	// Link events
	input wire logic [2:0]  port_link_up_n,
	input wire logic [2:0]  discard_req,
	input wire logic [2:0]  ur_route,
	input wire logic [2:0]  cfg_retrain_wr,
	input wire logic [2:0]  keep_cpl,
	input wire logic [2:0]  fc_init,
	input wire logic [59:0] fc_credits,
	input wire logic [2:0]  spl_send
);
	wire up_a = ltssm_state[3:0] >= `PCL_LT_L0 && ltssm_state[3:0] <= `PCL_LT_REC;
	wire [59:0] fc_exp = {`PCL_FC_CPLD, `PCL_FC_CPLH, `PCL_FC_NPD, `PCL_FC_NPH, `PCL_FC_PD,
		`PCL_FC_PH};

	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	link_up_a: assert property (1'b1 |=> port_link_up_n[0] == !$past(up_a))
		else $error("link-up output does not follow the training state");
	route_ur_a: assert property (ur_route == port_link_up_n)
		else $error("unsupported-request routing differs from link state");
	credit_adv_a: assert property ($fell(port_link_up_n[1]) |-> fc_init[1] && fc_credits == fc_exp)
		else $error("credits not advertised on link up");
	spl_up_a: assert property ($fell(port_link_up_n[1]) |-> spl_send[1])
		else $error("no slot power message on link up");
	spl_port_a: assert property (!spl_send[0])
		else $error("slot power message from the upstream port");
	discard_down_a: assert property ($rose(port_link_up_n[1]) && !keep_cpl[1] && !$past(keep_cpl[1])
		|-> discard_req[1])
		else $error("no discard on link down");
	keep_cpl_a: assert property (cfg_retrain_wr[2] |=> keep_cpl[2])
		else $error("retrain write completion not protected");
	cpl_guard_a: assert property (keep_cpl[2] && $past(keep_cpl[2]) |-> !discard_req[2])
		else $error("discard while a completion is protected");
	role_check_a: assert property (train_done[1] && partner_is_down[1] |=> role_mismatch[1])
		else $error("downstream port accepted a downstream partner");
	pol_detect_a: assert property (rx_sym_valid[0] && rx_sym_idx[3:0] >= `PCL_SYM_FIRST
		&& rx_sym[7:0] == 8'hb5 && ltssm_state[3:0] != `PCL_LT_L0 |=> lane_inverted[0])
		else $error("inverted ordered set not detected");

	link_up_c: cover property ($fell(port_link_up_n[1]));
	role_c: cover property (role_mismatch[1]);
	pol_c: cover property ($rose(lane_inverted[0]));
endmodule

bind pcl_top pcl_assertions i_chk (.clk_sys(clk_sys), .rst_n(rst_n), .rx_sym(rx_sym),
	.rx_sym_idx(rx_sym_idx), .rx_sym_valid(rx_sym_valid), .lane_inverted(lane_inverted),
	.ltssm_state(ltssm_state), .train_done(train_done), .partner_is_down(partner_is_down),
	.role_mismatch(role_mismatch), .port_link_up_n(port_link_up_n), .discard_req(discard_req),
	.ur_route(ur_route), .cfg_retrain_wr(cfg_retrain_wr), .keep_cpl(keep_cpl),
	.fc_init(fc_init), .fc_credits(fc_credits), .spl_send(spl_send));
`default_nettype wire

// *** tb/pcl_link_partner.sv ***
// Link partner model sending ordered sets on all twelve receive lanes.
`timescale 1ns/100ps
`default_nettype none

module pcl_link_partner
(
	// Clock and control
	input  wire logic        clk_sys,
	input  wire logic        send,
	input  wire logic [11:0] inv,
	// Receive lanes
	output var  logic [95:0] rx_sym = 96'h0,
	output var  logic [47:0] rx_sym_idx = 48'h0,
	output var  logic [11:0] rx_sym_valid = 12'h0
);
	logic [3:0] idx = 4'h0;

	// Identifier symbols fill slots six and up; elsewhere, and between sets, the lines toggle so
	// that a stale value can never pass for a fresh one.
	always @(posedge clk_sys)
	begin
		idx <= send ? idx + 4'h1 : 4'h0;
		rx_sym_valid <= {12{send}};
		for (int l = 0; l < 12; l++)
		begin
			rx_sym_idx[4*l +: 4] <= idx;
			if (send && idx >= 4'h6)
				rx_sym[8*l +: 8] <= inv[l] ? 8'hb5 : 8'h4a;
			else
				rx_sym[8*l +: 8] <= ~rx_sym[8*l +: 8];
		end
	end
endmodule
`default_nettype wire

// *** tb/pcl_top_tb_top.sv ***
// Self-checking bench for the port link control block.
`timescale 1ns/100ps
`default_nettype none
`include "pcl_defines.vh"

module pcl_top_tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic [2:0]  strap = 3'h5;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	wire  [31:0] reg_rdata;
	wire  [95:0] rx_sym;
	wire  [47:0] rx_sym_idx;
	wire  [11:0] rx_sym_valid;
	wire  [11:0] lane_inverted;
	wire  [11:0] lane_l1;
	wire  [95:0] rx_log_data;
	logic [11:0] ltssm_state = 12'h0;
	logic [2:0]  train_start = 3'h0;
	logic [2:0]  train_done = 3'h0;
	logic [17:0] partner_width = 18'h0;
	logic [2:0]  partner_is_down = 3'h0;
	wire  [2:0]  role_mismatch;
	wire  [2:0]  port_link_up_n;
	wire  [2:0]  discard_req;
	logic [2:0]  cfg_retrain_wr = 3'h0;
	logic [2:0]  cpl_sent = 3'h0;
	wire  [2:0]  keep_cpl;
	wire  [2:0]  fc_init;
	wire  [2:0]  spl_send;
	wire  [1:0]  intx_req;
	wire  [1:0]  msi_req;
	logic        p_send = 1'b0;
	logic [11:0] p_inv = 12'h0;
	int          n_fail = 0;
	int          total_checks = 0;
	int          k;

	always #2.5 clk_sys = ~clk_sys;

	pcl_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .port_a_reverse_strap(strap[0]),
		.port_b_reverse_strap(strap[1]), .port_c_reverse_strap(strap[2]), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rx_sym(rx_sym), .rx_sym_idx(rx_sym_idx), .rx_sym_valid(rx_sym_valid),
		.rx_log_data(rx_log_data), .lane_inverted(lane_inverted), .lane_l1(lane_l1),
		.ltssm_state(ltssm_state),
		.train_start(train_start), .train_done(train_done), .partner_width(partner_width),
		.partner_is_down(partner_is_down), .role_mismatch(role_mismatch),
		.port_link_up_n(port_link_up_n), .discard_req(discard_req), .ur_route(),
		.cfg_retrain_wr(cfg_retrain_wr), .cpl_sent(cpl_sent), .keep_cpl(keep_cpl),
		.fc_init(fc_init), .fc_credits(), .spl_send(spl_send), .intx_req(intx_req),
		.msi_req(msi_req));

	pcl_link_partner i_partner (.clk_sys(clk_sys), .send(p_send), .inv(p_inv), .rx_sym(rx_sym),
		.rx_sym_idx(rx_sym_idx), .rx_sym_valid(rx_sym_valid));

	// ----------------------------------------
	// Access and stimulus tasks
	// ----------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	task tick;
		@(posedge clk_sys);
		#1;
	endtask

	task start(input int p);
		@(posedge clk_sys);
		train_start[p] <= 1'b1;
		@(posedge clk_sys);
		train_start[p] <= 1'b0;
	endtask

	task train(input int p, input logic [5:0] pw, input logic dn);
		@(posedge clk_sys);
		partner_width[6*p +: 6] <= pw;
		partner_is_down[p] <= dn;
		train_done[p] <= 1'b1;
		@(posedge clk_sys);
		train_done[p] <= 1'b0;
	endtask

	task link(input int p, input logic [3:0] st);
		@(posedge clk_sys);
		ltssm_state[4*p +: 4] <= st;
		tick();
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		strap <= 3'h0;
		rd(`PCL_A_STS, 32'h5);
		rd(`PCL_A_CTL, 32'ha);
		wr(`PCL_A_STS, 32'h0);
		rd(`PCL_A_STS, 32'h5);
		rd(8'hfc, 32'h0);
		wr(`PCL_A_LCAP0, 32'h20);
		rd(`PCL_A_LCAP0, 32'h40);
		wr(`PCL_A_CTL, 32'hb);
		wr(`PCL_A_LCAP0, 32'h20);
		rd(`PCL_A_LCAP0, 32'h20);
		// Lanes of one link get different settings; the wait is bounded.
		@(posedge clk_sys);
		p_inv <= 12'h805;
		p_send <= 1'b1;
		k = 0;
		while (lane_inverted !== 12'h805 && k < 40)
		begin
			tick();
			k++;
		end
		chk(lane_inverted, 12'h805);
		if (lane_inverted !== 12'h805)
			end_sim();
		@(posedge clk_sys);
		p_send <= 1'b0;
		#1;
		// Every lane must come out of the mapper with the identifier restored to its true value.
		chk(rx_log_data === {12{8'h4a}}, 1'b1);
		// A reversed port, maximum lowered to x2 before a change that must wait.
		start(0);
		wr(`PCL_A_LCAP0, 32'h40);
		train(0, `PCL_W_X4, 1'b1);
		rd(`PCL_A_LSTS0, 32'h20);
		chk(lane_l1[3:0], 4'hc);
		start(0);
		train(0, `PCL_W_X1, 1'b1);
		rd(`PCL_A_LSTS0, 32'h10);
		chk(lane_l1[3:0], 4'h7);
		rd(`PCL_A_CTL, 32'hb);
		start(1);
		train(1, `PCL_W_X2, 1'b0);
		rd(`PCL_A_LSTS0 + 8'h4, 32'h20);
		chk(lane_l1[7:4], 4'hc);
		start(1);
		train(1, `PCL_W_X4, 1'b1);
		rd(`PCL_A_LSTS0 + 8'h4, 32'h4000);
		start(2);
		train(2, `PCL_W_X4, 1'b1);
		rd(`PCL_A_LSTS0 + 8'h8, 32'h40);
		for (int s = 3; s < 7; s++)
		begin
			link(0, 4'(s));
			chk(port_link_up_n[0], 1'b0);
		end
		// Link events on port B with MSI inside and INTx outside.
		wr(`PCL_A_IACT_INT, 32'h8);
		wr(`PCL_A_IACT_EXT, 32'h4);
		link(1, `PCL_LT_L0);
		chk({port_link_up_n[1], fc_init[1], spl_send[1], msi_req}, 5'b01101);
		tick();
		chk({msi_req, intx_req}, 4'b0010);
		// Port A is still up from the state walk, so its link-up bit stands as well.
		rd(`PCL_A_IST_INT, 32'h5);
		rd(`PCL_A_IST_EXT, 32'h5);
		wr(`PCL_A_IST_EXT, 32'h4);
		rd(`PCL_A_IST_EXT, 32'h1);
		chk(intx_req, 2'b00);
		wr(`PCL_A_SCAP0 + 8'h4, 32'h1234);
		#1;
		chk(spl_send, 3'b010);
		rd(`PCL_A_SCAP0 + 8'h4, 32'h1234);
		link(1, 4'h0);
		chk({port_link_up_n[1], discard_req[1]}, 2'b11);
		rd(`PCL_A_IST_INT, 32'hd);
		// A protected completion survives a link drop on port C.
		link(2, `PCL_LT_L0);
		@(posedge clk_sys);
		cfg_retrain_wr[2] <= 1'b1;
		@(posedge clk_sys);
		cfg_retrain_wr[2] <= 1'b0;
		link(2, `PCL_LT_REC);
		chk(port_link_up_n[2], 1'b0);
		link(2, 4'h0);
		chk({keep_cpl[2], discard_req[2]}, 2'b10);
		@(posedge clk_sys);
		cpl_sent[2] <= 1'b1;
		@(posedge clk_sys);
		cpl_sent[2] <= 1'b0;
		#1;
		chk(keep_cpl[2], 1'b0);
		end_sim();
	end
endmodule
`default_nettype wire
